//--- logic/cis_pkg.sv
// Shared constants and types for the instruction semantics core.
// Assumes a 16-bit datapath and the block-local opcode byte layout below.
package cis_pkg;

	// ==========================================================
	// Widths and opcode byte layout
	localparam int WORD_W = 16;        // Datapath word width
	localparam int BYTE_W = 8;         // Byte operand width
	localparam int OPC_LSB = 2;        // Operation field occupies bits 7..2
	localparam int OPC_W = 6;          // Width of the operation field
	localparam int LONG_BIT = 1;       // Selects the 4-byte form where one exists
	localparam int VAR_BIT = 0;        // Variant: signed, byte, by-two, negated, ...
	localparam int TRAP_W = 7;         // Width of the trap number

	// ==========================================================
	// Lengths, steps and reset values
	localparam logic [2:0] LEN_SHORT = 3'h2;        // Two-byte encoding
	localparam logic [2:0] LEN_LONG = 3'h4;         // Four-byte encoding
	localparam logic [15:0] STEP_ONE = 16'h0001;    // Compare-and-step by one
	localparam logic [15:0] STEP_TWO = 16'h0002;    // Compare-and-step by two
	localparam logic [15:0] IP_RESET = 16'h0000;    // Instruction pointer after reset
	localparam logic [7:0] WDT_LOW_CLEAR = 8'h00;   // Watchdog low byte after service
	localparam logic [15:0] WDT_RESET = 16'h0000;   // Watchdog count after reset

	// ==========================================================
	// Flag positions in the flag output
	localparam int FLAG_Z = 0;         // Zero
	localparam int FLAG_C = 1;         // Carry or borrow
	localparam int FLAG_N = 2;         // Negative

	// ==========================================================
	// Operations, in opcode field order
	typedef enum logic [5:0] {
		OPC_ADD,
		OPC_ADD_CARRY,
		OPC_SUBTRACT,
		OPC_SUBTRACT_CARRY,
		OPC_MULTIPLY,
		OPC_DIVIDE_SHORT,
		OPC_DIVIDE_LONG,
		OPC_COMPARE_STEP_DOWN,
		OPC_COMPARE_STEP_UP,
		OPC_NORMALIZE_COUNT,
		OPC_SHIFT_LEFT,
		OPC_SHIFT_RIGHT,
		OPC_SIGN_SHIFT_RIGHT,
		OPC_BYTE_EXTEND_MOVE,
		OPC_JUMP_BIT_ONE,
		OPC_JUMP_BIT_ZERO,
		OPC_BIT_COPY,
		OPC_MASKED_BYTE_FIELD,
		OPC_PUSH_AND_CALL,
		OPC_CONTEXT_SWITCH,
		OPC_NEAR_RETURN,
		OPC_TRAP,
		OPC_DEEP_SLEEP_ENTRY,
		OPC_PAGE_OVERRIDE,
		OPC_SEGMENT_OVERRIDE,
		OPC_WATCHDOG_SERVICE,
		OPC_COPROCESSOR,
		OPC_NOP
	} cis_op_t;

endpackage

//--- logic/cis_core.sv
// Single-cycle execution of the instruction subset of a 16-bit core.
// Assumes the fetch path presents the first opcode byte with its operands,
// and that register file, stack and datapath consume the pulsed outputs.
//
// Functional notes
// RULE1 - Multiply two registers, 16x16, two bytes
// RULE2 - Short divide low result word by register
// RULE3 - Long divide 32-bit pair by register
// RULE4 - Carry forms include carry; 2/4 bytes
// RULE5 - Compare then decrement register by 1/2
// RULE6 - Compare then increment register by 1/2
// RULE7 - Count shifts to normalize, store count
// RULE8 - Arithmetic right shift replicates sign bit
// RULE9 - Byte to word with sign/zero fill
// RULE10 - Jump if bit one; variant clears bit
// RULE11 - Jump if bit zero; variant sets bit
// RULE12 - Copy bit or inverse, four bytes
// RULE13 - Masked update of high/low byte
// RULE14 - Push register, then call absolute address
// RULE15 - Push register, then load new word
// RULE16 - Return; extended form pops a register
// RULE17 - Trap selects service routine by number
// RULE18 - Sleep entry needs interrupt pin low
// RULE19 - Page/segment prefixes in 2/4 bytes
// RULE20 - Coprocessor instructions occupy four bytes
// RULE21 - Length from first byte before advancing
// RULE22 - Watchdog service: reload high, clear low
module cis_core #(
	parameter int DATA_W = 16           // Datapath width; only 16 is served
) (
	input wire logic clk_i,             // Core clock, 200 MHz
	input wire logic rst_i,             // Asynchronous reset, active high
	input wire logic en_i,              // Clock enable; low freezes all state
	input wire logic fetch_valid_i,     // Opcode byte and operands valid
	input wire logic [7:0] opcode_i,    // First opcode byte
	input wire logic [15:0] opa_i,      // Destination register value
	input wire logic [15:0] opb_i,      // Source operand value
	input wire logic [15:0] imm_i,      // Immediate, target or displacement
	input wire logic bit_a_i,           // Addressed (destination) bit value
	input wire logic bit_b_i,           // Source bit value
	input wire logic carry_i,           // Carry flag from status word
	input wire logic [15:0] stack_top_i,  // Return address on stack top
	input wire logic [15:0] stack_next_i, // Word below the return address
	input wire logic [7:0] wdt_reload_i,  // Watchdog reload value
	input wire logic nmi_n_i,           // Interrupt pin, active low, async
	output logic done_o,                // One-cycle pulse per executed instruction
	output logic [2:0] len_o,           // Length of the last instruction
	output logic [15:0] ip_o,           // Instruction pointer
	output logic [15:0] result_o,       // Register write data
	output logic result_we_o,           // Register write pulse
	output logic [2:0] flags_o,         // Z, C, N of last arithmetic
	output logic bit_o,                 // Bit write data
	output logic bit_we_o,              // Bit write pulse
	output logic [31:0] md_o,           // Multiply/divide register pair
	output logic div_err_o,             // Divide by zero, pair kept
	output logic push_o,                // Stack push pulse
	output logic [15:0] push_data_o,    // Word pushed
	output logic [1:0] pop_o,           // Words popped (0..2)
	output logic trap_o,                // Trap entry pulse
	output logic [6:0] trap_num_o,      // Trap number
	output logic sleep_o,               // Power down state
	output logic prefix_page_o,         // Page prefix pulse
	output logic prefix_seg_o,          // Segment prefix pulse
	output logic prefix_reg_o,          // Prefix also selects register bank
	output logic cop_o,                 // Coprocessor issue pulse
	output logic [15:0] wdt_o           // Watchdog count
);

	// ==========================================================
	// Elaboration check
	if (DATA_W != cis_pkg::WORD_W) begin : g_width_check
		$error("cis_core serves only a 16-bit datapath");
	end

	// ==========================================================
	// Helper functions

	// Length from the first byte alone
	function automatic logic [2:0] len_of(input cis_pkg::cis_op_t op, input logic lng);
		unique case (op)
			cis_pkg::OPC_ADD, cis_pkg::OPC_ADD_CARRY, cis_pkg::OPC_SUBTRACT,
			cis_pkg::OPC_SUBTRACT_CARRY, cis_pkg::OPC_COMPARE_STEP_DOWN,
			cis_pkg::OPC_COMPARE_STEP_UP, cis_pkg::OPC_BYTE_EXTEND_MOVE,
			cis_pkg::OPC_PAGE_OVERRIDE, cis_pkg::OPC_SEGMENT_OVERRIDE:
				return lng ? cis_pkg::LEN_LONG : cis_pkg::LEN_SHORT; // RULE4 RULE19
			cis_pkg::OPC_JUMP_BIT_ONE, cis_pkg::OPC_JUMP_BIT_ZERO,
			cis_pkg::OPC_BIT_COPY, cis_pkg::OPC_MASKED_BYTE_FIELD,
			cis_pkg::OPC_PUSH_AND_CALL, cis_pkg::OPC_CONTEXT_SWITCH,
			cis_pkg::OPC_DEEP_SLEEP_ENTRY, cis_pkg::OPC_WATCHDOG_SERVICE,
			cis_pkg::OPC_COPROCESSOR:
				return cis_pkg::LEN_LONG; // RULE20
			default:
				return cis_pkg::LEN_SHORT; // RULE1
		endcase
	endfunction

	// Add or subtract, word or byte, with optional carry; {carry, result}
	function automatic logic [16:0] add_sub(input logic [15:0] a, input logic [15:0] b,
			input logic cin, input logic sub, input logic byt);
		logic [16:0] w;
		logic [8:0] s;
		w = sub ? ({1'b0, a} - {1'b0, b} - {16'h0000, cin})
			: ({1'b0, a} + {1'b0, b} + {16'h0000, cin});
		s = sub ? ({1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, cin})
			: ({1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin});
		if (byt) begin
			return {s[8], a[15:8], s[7:0]};
		end
		return w;
	endfunction

	// Shift count that brings the leading one to the top; zero gives zero
	function automatic logic [15:0] norm_count(input logic [15:0] v);
		logic [15:0] n;
		logic found;
		n = 16'h0000;
		found = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (!found && v[i]) begin
				found = 1'b1;
				n = 16'(15 - i);
			end
		end
		return n;
	endfunction

	// ==========================================================
	// Pin synchroniser; first stage feeds only the second
	logic nmi_meta_q;     // First stage
	logic nmi_sync_n_q;   // Second stage, safe to read

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nmi_meta_q <= 1'b1;
			nmi_sync_n_q <= 1'b1;
		end else if (en_i) begin
			nmi_meta_q <= nmi_n_i;
			nmi_sync_n_q <= nmi_meta_q;
		end
	end

	// ==========================================================
	// Decode of the presented byte
	cis_pkg::cis_op_t op_w;   // Operation field
	logic acc_w;              // Instruction accepted this cycle
	logic var_w;              // Variant bit
	logic [2:0] len_w;        // Encoded length
	logic [15:0] ip_seq_w;    // Sequential next address

	assign op_w = cis_pkg::cis_op_t'(opcode_i[cis_pkg::OPC_LSB +: cis_pkg::OPC_W]);
	assign acc_w = en_i && fetch_valid_i;
	assign var_w = opcode_i[cis_pkg::VAR_BIT];
	assign len_w = len_of(op_w, opcode_i[cis_pkg::LONG_BIT]); // RULE21

	// ==========================================================
	// Architectural state and output registers
	logic done_q, done_d;
	logic [2:0] len_q, len_d;
	logic [15:0] ip_q, ip_d;
	logic [15:0] result_q, result_d;
	logic result_we_q, result_we_d;
	logic [2:0] flags_q, flags_d;
	logic bit_q, bit_d;
	logic bit_we_q, bit_we_d;
	logic [31:0] md_q, md_d;
	logic div_err_q, div_err_d;
	logic push_q, push_d;
	logic [15:0] push_data_q, push_data_d;
	logic [1:0] pop_q, pop_d;
	logic trap_q, trap_d;
	logic [6:0] trap_num_q, trap_num_d;
	logic sleep_q, sleep_d;
	logic prefix_page_q, prefix_page_d;
	logic prefix_seg_q, prefix_seg_d;
	logic prefix_reg_q, prefix_reg_d;
	logic cop_q, cop_d;
	logic [15:0] wdt_q, wdt_d;

	// Sequential address, once the pointer register is declared
	assign ip_seq_w = ip_q + {13'h0000, len_w}; // RULE21

	// Datapath intermediates, driven only by the process below
	logic [16:0] arith_w;           // Carry and result of add/subtract/compare
	logic [31:0] prod_w;            // Product
	logic [31:0] quo_w, rem_w;      // Quotient and remainder
	logic [31:0] dvd_w, dvs_w;      // Dividend and extended divisor
	logic [15:0] step_w;            // Compare-and-step amount
	logic taken_w;                  // Relative branch taken

	// Next state: everything is single cycle, so one decode feeds all registers
	always_comb begin
		done_d = 1'b0;
		len_d = len_q;
		ip_d = ip_q;
		result_d = result_q;
		result_we_d = 1'b0;
		flags_d = flags_q;
		bit_d = bit_q;
		bit_we_d = 1'b0;
		md_d = md_q;
		div_err_d = 1'b0;
		push_d = 1'b0;
		push_data_d = push_data_q;
		pop_d = 2'h0;
		trap_d = 1'b0;
		trap_num_d = trap_num_q;
		sleep_d = sleep_q && !nmi_sync_n_q ? 1'b1 : 1'b0; // Interrupt pin high wakes
		prefix_page_d = 1'b0;
		prefix_seg_d = 1'b0;
		prefix_reg_d = prefix_reg_q;
		cop_d = 1'b0;
		wdt_d = wdt_q + 16'h0001;   // Free-running between services
		arith_w = 17'h00000;
		prod_w = 32'h00000000;
		quo_w = 32'h00000000;
		rem_w = 32'h00000000;
		dvd_w = 32'h00000000;
		dvs_w = 32'h00000000;
		step_w = var_w ? cis_pkg::STEP_TWO : cis_pkg::STEP_ONE;
		taken_w = 1'b0;
		if (acc_w && !sleep_q) begin
			done_d = 1'b1;
			len_d = len_w;
			ip_d = ip_seq_w;
			unique case (op_w)
				// Plain and carry forms; variant selects byte width
				cis_pkg::OPC_ADD, cis_pkg::OPC_ADD_CARRY,
				cis_pkg::OPC_SUBTRACT, cis_pkg::OPC_SUBTRACT_CARRY: begin
					arith_w = add_sub(opa_i, opb_i,
						(op_w == cis_pkg::OPC_ADD_CARRY || op_w == cis_pkg::OPC_SUBTRACT_CARRY)
						&& carry_i,
						op_w == cis_pkg::OPC_SUBTRACT || op_w == cis_pkg::OPC_SUBTRACT_CARRY,
						var_w); // RULE4
					result_d = arith_w[15:0];
					result_we_d = 1'b1;
					flags_d[cis_pkg::FLAG_C] = arith_w[16];
					flags_d[cis_pkg::FLAG_Z] = var_w ? (arith_w[7:0] == 8'h00)
						: (arith_w[15:0] == 16'h0000);
					flags_d[cis_pkg::FLAG_N] = var_w ? arith_w[7] : arith_w[15];
				end
				// Variant set means signed
				cis_pkg::OPC_MULTIPLY: begin
					if (var_w) begin
						// Widen first so the product keeps all 32 bits
						prod_w = $unsigned($signed({{16{opa_i[15]}}, opa_i})
							* $signed({{16{opb_i[15]}}, opb_i})); // RULE1
					end else begin
						prod_w = {16'h0000, opa_i} * {16'h0000, opb_i}; // RULE1
					end
					md_d = prod_w;
					flags_d[cis_pkg::FLAG_Z] = (prod_w == 32'h00000000);
					flags_d[cis_pkg::FLAG_N] = prod_w[31];
				end
				// Short takes the low word, long the whole pair
				cis_pkg::OPC_DIVIDE_SHORT, cis_pkg::OPC_DIVIDE_LONG: begin
					if (op_w == cis_pkg::OPC_DIVIDE_SHORT) begin
						dvd_w = var_w ? {{16{md_q[15]}}, md_q[15:0]} : {16'h0000, md_q[15:0]}; // RULE2
					end else begin
						dvd_w = md_q; // RULE3
					end
					dvs_w = var_w ? {{16{opb_i[15]}}, opb_i} : {16'h0000, opb_i};
					if (opb_i == 16'h0000) begin
						div_err_d = 1'b1;   // Pair kept rather than filled with junk
					end else begin
						quo_w = var_w ? $unsigned($signed(dvd_w) / $signed(dvs_w)) : dvd_w / dvs_w;
						rem_w = var_w ? $unsigned($signed(dvd_w) % $signed(dvs_w)) : dvd_w % dvs_w;
						md_d = {rem_w[15:0], quo_w[15:0]}; // RULE2 RULE3
					end
				end
				// Compare against the register, then step it
				cis_pkg::OPC_COMPARE_STEP_DOWN, cis_pkg::OPC_COMPARE_STEP_UP: begin
					arith_w = add_sub(opa_i, opb_i, 1'b0, 1'b1, 1'b0);
					flags_d[cis_pkg::FLAG_C] = arith_w[16];
					flags_d[cis_pkg::FLAG_Z] = (arith_w[15:0] == 16'h0000);
					flags_d[cis_pkg::FLAG_N] = arith_w[15];
					if (op_w == cis_pkg::OPC_COMPARE_STEP_DOWN) begin
						result_d = opa_i - step_w; // RULE5
					end else begin
						result_d = opa_i + step_w; // RULE6
					end
					result_we_d = 1'b1;
				end
				cis_pkg::OPC_NORMALIZE_COUNT: begin
					result_d = norm_count(opb_i); // RULE7
					result_we_d = 1'b1;
				end
				// Shift count in the low four bits of the source
				cis_pkg::OPC_SHIFT_LEFT: begin
					result_d = opa_i << opb_i[3:0];
					result_we_d = 1'b1;
				end
				cis_pkg::OPC_SHIFT_RIGHT: begin
					result_d = opa_i >> opb_i[3:0];
					result_we_d = 1'b1;
				end
				cis_pkg::OPC_SIGN_SHIFT_RIGHT: begin
					result_d = 16'($signed(opa_i) >>> opb_i[3:0]); // RULE8
					result_we_d = 1'b1;
				end
				// Variant set means sign extension
				cis_pkg::OPC_BYTE_EXTEND_MOVE: begin
					result_d = {{8{var_w && opb_i[7]}}, opb_i[7:0]}; // RULE9
					result_we_d = 1'b1;
				end
				cis_pkg::OPC_JUMP_BIT_ONE, cis_pkg::OPC_JUMP_BIT_ZERO: begin
					taken_w = (op_w == cis_pkg::OPC_JUMP_BIT_ONE) ? bit_a_i : !bit_a_i;
					if (taken_w) begin
						ip_d = ip_seq_w + imm_i;
						bit_d = (op_w == cis_pkg::OPC_JUMP_BIT_ZERO); // RULE10 RULE11
						bit_we_d = var_w; // RULE10 RULE11
					end
				end
				cis_pkg::OPC_BIT_COPY: begin
					bit_d = bit_b_i ^ var_w; // RULE12
					bit_we_d = 1'b1;
				end
				// Low byte of immediate is the mask, high byte the data
				cis_pkg::OPC_MASKED_BYTE_FIELD: begin
					if (var_w) begin
						result_d = {(opa_i[15:8] & ~imm_i[7:0]) | (imm_i[15:8] & imm_i[7:0]),
							opa_i[7:0]}; // RULE13
					end else begin
						result_d = {opa_i[15:8],
							(opa_i[7:0] & ~imm_i[7:0]) | (imm_i[15:8] & imm_i[7:0])}; // RULE13
					end
					result_we_d = 1'b1;
				end
				cis_pkg::OPC_PUSH_AND_CALL: begin
					push_d = 1'b1;
					push_data_d = opa_i; // RULE14
					ip_d = imm_i; // RULE14
				end
				cis_pkg::OPC_CONTEXT_SWITCH: begin
					push_d = 1'b1;
					push_data_d = opa_i; // RULE15
					result_d = opb_i; // RULE15
					result_we_d = 1'b1;
				end
				// Extended form also pops the word below the return address
				cis_pkg::OPC_NEAR_RETURN: begin
					ip_d = stack_top_i; // RULE16
					pop_d = var_w ? 2'h2 : 2'h1;
					result_d = var_w ? stack_next_i : result_q; // RULE16
					result_we_d = var_w;
				end
				cis_pkg::OPC_TRAP: begin
					trap_d = 1'b1;
					trap_num_d = imm_i[cis_pkg::TRAP_W-1:0]; // RULE17
					push_d = 1'b1;
					push_data_d = ip_seq_w;
				end
				// Refused as a no-op while the interrupt pin is high
				cis_pkg::OPC_DEEP_SLEEP_ENTRY: begin
					sleep_d = !nmi_sync_n_q; // RULE18
				end
				cis_pkg::OPC_PAGE_OVERRIDE: begin
					prefix_page_d = 1'b1; // RULE19
					prefix_reg_d = var_w;
				end
				cis_pkg::OPC_SEGMENT_OVERRIDE: begin
					prefix_seg_d = 1'b1; // RULE19
					prefix_reg_d = var_w;
				end
				cis_pkg::OPC_WATCHDOG_SERVICE: begin
					wdt_d = {wdt_reload_i, cis_pkg::WDT_LOW_CLEAR}; // RULE22
				end
				cis_pkg::OPC_COPROCESSOR: begin
					cop_d = 1'b1; // RULE20
				end
				// Nop and unused codes only advance
				default: begin
					ip_d = ip_seq_w;
				end
			endcase
		end
	end

	// Registers only; enable low freezes every one of them
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
			len_q <= cis_pkg::LEN_SHORT;
			ip_q <= cis_pkg::IP_RESET;
			result_q <= 16'h0000;
			result_we_q <= 1'b0;
			flags_q <= 3'h0;
			bit_q <= 1'b0;
			bit_we_q <= 1'b0;
			md_q <= 32'h00000000;
			div_err_q <= 1'b0;
			push_q <= 1'b0;
			push_data_q <= 16'h0000;
			pop_q <= 2'h0;
			trap_q <= 1'b0;
			trap_num_q <= 7'h00;
			sleep_q <= 1'b0;
			prefix_page_q <= 1'b0;
			prefix_seg_q <= 1'b0;
			prefix_reg_q <= 1'b0;
			cop_q <= 1'b0;
			wdt_q <= cis_pkg::WDT_RESET;
		end else if (en_i) begin
			done_q <= done_d;
			len_q <= len_d;
			ip_q <= ip_d;
			result_q <= result_d;
			result_we_q <= result_we_d;
			flags_q <= flags_d;
			bit_q <= bit_d;
			bit_we_q <= bit_we_d;
			md_q <= md_d;
			div_err_q <= div_err_d;
			push_q <= push_d;
			push_data_q <= push_data_d;
			pop_q <= pop_d;
			trap_q <= trap_d;
			trap_num_q <= trap_num_d;
			sleep_q <= sleep_d;
			prefix_page_q <= prefix_page_d;
			prefix_seg_q <= prefix_seg_d;
			prefix_reg_q <= prefix_reg_d;
			cop_q <= cop_d;
			wdt_q <= wdt_d;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops
	assign done_o = done_q;
	assign len_o = len_q;
	assign ip_o = ip_q;
	assign result_o = result_q;
	assign result_we_o = result_we_q;
	assign flags_o = flags_q;
	assign bit_o = bit_q;
	assign bit_we_o = bit_we_q;
	assign md_o = md_q;
	assign div_err_o = div_err_q;
	assign push_o = push_q;
	assign push_data_o = push_data_q;
	assign pop_o = pop_q;
	assign trap_o = trap_q;
	assign trap_num_o = trap_num_q;
	assign sleep_o = sleep_q;
	assign prefix_page_o = prefix_page_q;
	assign prefix_seg_o = prefix_seg_q;
	assign prefix_reg_o = prefix_reg_q;
	assign cop_o = cop_q;
	assign wdt_o = wdt_q;

	// ==========================================================
	// Assertions
	logic go_w;   // Accepted and awake
	assign go_w = acc_w && !sleep_q;

	property p_mul_unsigned;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_MULTIPLY && !var_w)
		|=> (md_o == {16'h0000, $past(opa_i)} * {16'h0000, $past(opb_i)}) && len_o == 3'h2;
	endproperty
	a_mul_unsigned: assert property (p_mul_unsigned) else $error("multiply product wrong"); // RULE1

	property p_step_up;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_COMPARE_STEP_UP && var_w)
		|=> result_we_o && result_o == $past(opa_i) + 16'h0002;
	endproperty
	a_step_up: assert property (p_step_up) else $error("step up by two wrong"); // RULE6

	property p_sign_shift;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_SIGN_SHIFT_RIGHT && opa_i[15] && opb_i[3:0] == 4'h4)
		|=> result_o[15:11] == 5'h1f;
	endproperty
	a_sign_shift: assert property (p_sign_shift) else $error("sign not replicated"); // RULE8

	property p_zero_extend;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_BYTE_EXTEND_MOVE && !var_w)
		|=> result_o[15:8] == 8'h00 && result_o[7:0] == $past(opb_i[7:0]);
	endproperty
	a_zero_extend: assert property (p_zero_extend) else $error("zero extension wrong"); // RULE9

	property p_jump_clear;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_JUMP_BIT_ONE && var_w && bit_a_i)
		|=> bit_we_o && !bit_o && ip_o == $past(ip_o) + 16'h0004 + $past(imm_i);
	endproperty
	a_jump_clear: assert property (p_jump_clear) else $error("taken jump did not clear bit"); // RULE10

	property p_bit_copy;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_BIT_COPY)
		|=> bit_we_o && bit_o == ($past(bit_b_i) ^ $past(var_w)) && len_o == 3'h4;
	endproperty
	a_bit_copy: assert property (p_bit_copy) else $error("bit copy wrong"); // RULE12

	property p_push_call;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_PUSH_AND_CALL)
		|=> push_o && push_data_o == $past(opa_i) && ip_o == $past(imm_i);
	endproperty
	a_push_call: assert property (p_push_call) else $error("push and call wrong"); // RULE14

	property p_sleep_refused;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_DEEP_SLEEP_ENTRY && nmi_sync_n_q) |=> !sleep_o;
	endproperty
	a_sleep_refused: assert property (p_sleep_refused) else $error("sleep entered with pin high"); // RULE18

	property p_wdt_service;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_WATCHDOG_SERVICE)
		|=> wdt_o == {$past(wdt_reload_i), 8'h00};
	endproperty
	a_wdt_service: assert property (p_wdt_service) else $error("watchdog service wrong"); // RULE22

	property p_cop_len;
		@(posedge clk_i) disable iff (rst_i)
		(go_w && op_w == cis_pkg::OPC_COPROCESSOR) |=> cop_o && len_o == 3'h4;
	endproperty
	a_cop_len: assert property (p_cop_len) else $error("coprocessor length not four"); // RULE20

endmodule

//--- test/cis_fetch_model.sv
// Fetch-side model: hands one opcode byte to the core per request.
// Assumes the core takes the byte at the edge where valid is high.
module cis_fetch_model (
	input wire logic clk_i,      // Core clock
	output logic valid_o,        // Opcode byte valid
	output logic [7:0] opcode_o  // First opcode byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Idle until asked
	initial begin
		valid_o = 1'b0;
		opcode_o = 8'h00;
	end
	// Byte stands one edge; afterwards it is inverted so a late read shows up
	task automatic send(input logic [7:0] op);
		@(posedge clk_i);
		valid_o <= 1'b1;
		opcode_o <= op;
		@(posedge clk_i);
		valid_o <= 1'b0;
		opcode_o <= ~op;
	endtask
endmodule

//--- test/cis_core_tb.sv
// Bench for the instruction core, one task per scenario.
// Assumes one-cycle answers and the opcode layout of the package.
module cis_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic clk = 1'b0, rst = 1'b1, cy = 1'b0, ba = 1'b0, nmi_n = 1'b1, fv, dn, bo, bwe, de, pu;
	logic tr, sl, pp, ps, pr, co, rwe, bb = 1'b0;
	logic [15:0] zw = 16'h0000, a = 16'h0000, b = 16'h0000, im = 16'h0000, top = 16'h0000;
	logic [15:0] nxt = 16'h0000, ip_e = 16'h0000, ip, res, pd, wdt, r0;
	logic [7:0] opc;
	logic [2:0] len, fl;
	logic [31:0] md;
	logic [1:0] pop;
	logic [6:0] tn;
	int fails = 0, n_checks = 0;
	initial forever #2.5 clk = ~clk;
	cis_fetch_model fetch_u (.clk_i(clk), .valid_o(fv), .opcode_o(opc));
	cis_core dut_u (.clk_i(clk), .rst_i(rst), .en_i(1'b1), .fetch_valid_i(fv), .opcode_i(opc),
		.opa_i(a), .opb_i(b), .imm_i(im), .bit_a_i(ba), .bit_b_i(bb), .carry_i(cy),
		.stack_top_i(top), .stack_next_i(nxt), .wdt_reload_i(8'h5a), .nmi_n_i(nmi_n),
		.done_o(dn), .len_o(len), .ip_o(ip), .result_o(res), .result_we_o(rwe), .flags_o(fl),
		.bit_o(bo), .bit_we_o(bwe), .md_o(md), .div_err_o(de), .push_o(pu), .push_data_o(pd),
		.pop_o(pop), .trap_o(tr), .trap_num_o(tn), .sleep_o(sl), .prefix_page_o(pp),
		.prefix_seg_o(ps), .prefix_reg_o(pr), .cop_o(co), .wdt_o(wdt));
	// ==========================================================
	// Helpers
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] op(input cis_pkg::cis_op_t o, input logic [1:0] lv);
		return {o, lv};
	endfunction
	// Operands at one edge, byte at the next; judged once the answer lands
	task automatic run(input logic [7:0] o, input logic [15:0] x, y, z, input logic j = 1'b0,
		input logic [15:0] t = 16'h0000, input logic k = 1'b1);
		@(posedge clk);
		a <= x;
		b <= y;
		im <= z;
		fetch_u.send(o);
		#1;
		ip_e = j ? t : ip_e + (o[1] ? 16'h0004 : 16'h0002);
		chk("done", dn, 1);
		chk("len", len, o[1] ? 3'h4 : 3'h2);
		if (k) chk("ip", ip, ip_e);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_muldiv();
		run(op(cis_pkg::OPC_MULTIPLY, 2'b01), 16'hffff, 16'h0002, zw);
		chk("muls", md, 32'hfffffffe);
		run(op(cis_pkg::OPC_MULTIPLY, 2'b00), 16'h1234, 16'h0100, zw);
		chk("mul", md, 32'h00123400);
		run(op(cis_pkg::OPC_DIVIDE_LONG, 2'b00), zw, 16'h0100, zw);
		chk("divl", md, 32'h00001234);
		run(op(cis_pkg::OPC_DIVIDE_SHORT, 2'b00), zw, 16'h0010, zw);
		chk("div", md, 32'h00040123);
		run(op(cis_pkg::OPC_DIVIDE_SHORT, 2'b00), zw, zw, zw);
		chk("div0", {de, md[30:0]}, 32'h80040123);
		run(op(cis_pkg::OPC_DIVIDE_SHORT, 2'b01), zw, 16'hffff, zw);
		chk("divs", md, 32'h0000fedd);
	endtask
	task automatic t_arith();
		@(posedge clk);
		cy <= 1'b1;
		run(op(cis_pkg::OPC_ADD_CARRY, 2'b10), 16'hffff, zw, zw);
		chk("addc", {res, 13'h0, fl}, 32'h00000003);
		run(op(cis_pkg::OPC_SUBTRACT_CARRY, 2'b00), 16'h0005, 16'h0003, zw);
		chk("subc", res, 32'h1);
		run(op(cis_pkg::OPC_COMPARE_STEP_DOWN, 2'b10), 16'h0005, zw, zw);
		chk("down", res, 32'h4);
		run(op(cis_pkg::OPC_COMPARE_STEP_UP, 2'b01), 16'h0005, zw, zw);
		chk("up", res, 32'h7);
		run(op(cis_pkg::OPC_NORMALIZE_COUNT, 2'b00), zw, 16'h0100, zw);
		chk("norm", {rwe, res}, 32'h10007);
		run(op(cis_pkg::OPC_SIGN_SHIFT_RIGHT, 2'b00), 16'h8000, 16'h0004, zw);
		chk("sign_shift_right_op", res, 32'hf800);
		run(op(cis_pkg::OPC_SHIFT_RIGHT, 2'b00), 16'h8000, 16'h0004, zw);
		chk("shr", res, 32'h0800);
		run(op(cis_pkg::OPC_BYTE_EXTEND_MOVE, 2'b00), zw, 16'h0080, zw);
		r0 = res;
		run(op(cis_pkg::OPC_BYTE_EXTEND_MOVE, 2'b11), zw, 16'h0080, zw);
		chk("ext", {r0 ^ res, r0 | res}, 32'hff00ff80);
	endtask
	task automatic t_bits();
		@(posedge clk);
		ba <= 1'b1;
		run(op(cis_pkg::OPC_JUMP_BIT_ONE, 2'b11), zw, zw, 16'h0010, 1'b1, ip_e + 16'h0014);
		chk("jbc", {bwe, bo}, 2'b10);
		@(posedge clk);
		ba <= 1'b0;
		run(op(cis_pkg::OPC_JUMP_BIT_ZERO, 2'b11), zw, zw, 16'h0020, 1'b1, ip_e + 16'h0024);
		chk("jnbs", {bwe, bo}, 2'b11);
		run(op(cis_pkg::OPC_BIT_COPY, 2'b11), zw, zw, zw);
		chk("bmovn", {bwe, bo}, 2'b11);
		@(posedge clk);
		bb <= 1'b1;
		run(op(cis_pkg::OPC_BIT_COPY, 2'b10), zw, zw, zw);
		chk("bmov", {bwe, bo}, 2'b11);
		run(op(cis_pkg::OPC_MASKED_BYTE_FIELD, 2'b11), 16'h1234, zw, 16'h56f0);
		chk("bfld", res, 32'h5234);
	endtask
	task automatic t_stack();
		run(op(cis_pkg::OPC_PUSH_AND_CALL, 2'b10), 16'habcd, zw, 16'h0400, 1'b1, 16'h0400);
		chk("push_and_call_op", {rwe, pu, pd}, 32'h1abcd);
		run(op(cis_pkg::OPC_CONTEXT_SWITCH, 2'b10), 16'h1111, 16'h2222, zw);
		chk("context_switch_op", {pd, res}, 32'h11112222);
		@(posedge clk);
		top <= 16'h0300;
		nxt <= 16'h5555;
		r0 = ip_e;
		run(op(cis_pkg::OPC_TRAP, 2'b00), zw, zw, 16'h007f, 1'b0, zw, 1'b0);
		chk("trap", {tr, tn, pd}, {8'hff, r0 + 16'h0002});
		run(op(cis_pkg::OPC_NEAR_RETURN, 2'b01), zw, zw, zw, 1'b1, 16'h0300);
		chk("retp", {pop, res}, 32'h25555);
	endtask
	task automatic t_sys();
		run(op(cis_pkg::OPC_WATCHDOG_SERVICE, 2'b10), zw, zw, zw);
		chk("wdt", wdt, 32'h5a00);
		run(op(cis_pkg::OPC_PAGE_OVERRIDE, 2'b11), zw, zw, zw);
		chk("extpr", {pp, ps, pr}, 3'b101);
		run(op(cis_pkg::OPC_SEGMENT_OVERRIDE, 2'b00), zw, zw, zw);
		chk("exts", {pp, ps, pr}, 3'b010);
		run(op(cis_pkg::OPC_COPROCESSOR, 2'b10), zw, zw, zw);
		chk("cop", co, 1);
		run(op(cis_pkg::OPC_DEEP_SLEEP_ENTRY, 2'b10), zw, zw, zw);
		chk("nosleep", sl, 0);
		@(posedge clk);
		nmi_n <= 1'b0;
		repeat (3) @(posedge clk);
		run(op(cis_pkg::OPC_DEEP_SLEEP_ENTRY, 2'b10), zw, zw, zw);
		chk("sleep", sl, 1);
		@(posedge clk);
		nmi_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("wake", sl, 0);
	endtask
	// ==========================================================
	// Verdict and sequence
	task automatic test_done();
		if (fails == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_muldiv();
		t_arith();
		t_bits();
		t_stack();
		t_sys();
		test_done();
	end
	// About 110 cycles of work; cut a hang well beyond that
	initial begin
		#5000;
		fails++;
		test_done();
	end
endmodule
